// File: design/tape_verify_pkg.sv
// Functional notes
// - Each character issues a verify slot after the reset slot, sampling storage.
// - Alarm slot 110 us after verify; any storage bit set flags verify alarm.
// - A mark at a read contact sets its storage bit at read slot.
// - A verify mark toggles its storage bit at verify slot; space leaves it.
// - Space read and space verified leaves the bit clear, no alarm.
// - Feed contact of one of six readers chosen by one-hot select inputs.
// - Four-bit counter of step pulses; reaching 15 raises the feed alarm.
// - A feed contact transition after a step clears the step counter.
// - Serializer gets reader data, header characters, or the idle character.
// - With no character available outside a header sequence, all eight levels go out as marks.
// - While a number is being sent, reader data is kept from storage.
// - During a header sequence levels 1, 7 and 8 are forced to space.
// - During a header sequence levels 2 to 6 carry generator values.
// - Reader data passes only with character available and no number sent.
// - On-line sets character available at read slot; next step clears it.
// - Next step clears the verify alarm; suppressed during header sequence.
// - Verify slot comes 1.6 ms after reset slot, which follows the step.
package tape_verify_pkg;
    localparam int LEVELS = 8;
    localparam int READERS = 6;
    localparam int CLK_MHZ = 25;
    // Slot delays in microseconds
    localparam int RESET_US = 800;
    localparam int VERIFY_US = 1600;
    localparam int ALARM_US = 110;
    localparam int READ_US = 110;
    localparam int RESET_CYC = RESET_US * CLK_MHZ;
    localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ;
    localparam int ALARM_CYC = ALARM_US * CLK_MHZ;
    localparam int READ_CYC = READ_US * CLK_MHZ;
    localparam logic [3:0] FEED_LIMIT = 4'h f;
    localparam int FIFO_DEPTH = 8;
    // Register map, byte addresses
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] CHAR_OFS = 12'h008;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int ONLINE_BIT = 0;
    localparam logic [7:0] IDLE_CHAR = 8'hff;
    typedef enum logic [2:0] {
        PH_IDLE, PH_RESET, PH_VERIFY, PH_ALARM, PH_READ
    } phase_t;
endpackage

// File: design/tape_verify.sv
`timescale 1ns/10ps
// Small queue with registered head word and registered full flag
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
            $error("char_fifo: depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic full;
        logic ov;
        logic [WIDTH-1:0] od;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;

    // Head stage refills from the queue; full flag registered for timing
    always_comb begin
        logic take;
        logic give;
        take = 1'b0;
        give = 1'b0;
        next_s = s;
        if (s.ov && out_ready) begin
            next_s.ov = 1'b0;
        end
        take = in_valid && !s.full;
        if (take) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + PW'(1);
        end
        if (!next_s.ov && s.cnt != '0) begin
            next_s.od = s.mem[s.rp];
            next_s.ov = 1'b1;
            next_s.rp = s.rp + PW'(1);
            give = 1'b1;
        end
        next_s.cnt = s.cnt + CW'(take) - CW'(give);
        // Head stage counts as a slot, so DEPTH words in all
        next_s.full = ((next_s.cnt + CW'(next_s.ov)) == FULL_CNT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = !s.full;
    assign out_valid = s.ov;
    assign out_data = s.od;
endmodule // char_fifo

// Read/verify checking, feed watch and output gating for the tape sender
module tape_verify #(
    parameter int RESET_CYC = tape_verify_pkg::RESET_CYC,
    parameter int VERIFY_CYC = tape_verify_pkg::VERIFY_CYC,
    parameter int FIFO_DEPTH = tape_verify_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reader contacts, eight levels per reader, mark = 1
    input wire logic [47:0] read_contact,
    input wire logic [47:0] verify_contact,
    input wire logic [5:0] feed_contact,
    // Sequence control
    input wire logic [5:0] reader_select,
    input wire logic reader_step,
    // Message header generator
    input wire logic header_sending,
    input wire logic [4:0] header_levels,
    // Serializer side
    output logic [7:0] ser_data,
    output logic ser_valid,
    input wire logic ser_ready,
    output logic step_permit,
    // Alarms to reader logic
    output logic verify_alarm,
    output logic feed_alarm,
    output logic char_available
);
    localparam int TW = 16;
    localparam logic [TW-1:0] RST_LD = TW'(RESET_CYC - 1);
    localparam logic [TW-1:0] VFY_LD = TW'(VERIFY_CYC - 1);
    localparam logic [TW-1:0] ALM_LD =
        TW'(tape_verify_pkg::ALARM_CYC - 1);
    localparam logic [TW-1:0] RD_LD =
        TW'(tape_verify_pkg::READ_CYC - 1);

    initial begin
        if (RESET_CYC < 1 || RESET_CYC > 65536 ||
            VERIFY_CYC < 1 || VERIFY_CYC > 65536)
            $error("tape_verify: slot counts must fit 16 bits");
    end

    typedef struct packed {
        logic [47:0] rd_s1;
        logic [47:0] rd_s2;
        logic [47:0] vf_s1;
        logic [47:0] vf_s2;
        logic [5:0] fd_s1;
        logic [5:0] fd_s2;
        logic feed_last;
        tape_verify_pkg::phase_t phase;
        logic [TW-1:0] timer;
        logic [7:0] storage;
        logic primed;
        logic valarm;
        logic falarm;
        logic cavail;
        logic [3:0] steps;
        logic push;
        logic [7:0] push_data;
        logic on_line;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;
    logic fifo_ready;
    logic fifo_full_q;

    // One-hot pick of the selected reader's eight levels
    function automatic logic [7:0] pick8(input logic [47:0] v,
                                         input logic [5:0] sel);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < tape_verify_pkg::READERS; i++) begin
            if (sel[i])
                r = r | v[i*8 +: 8];
        end
        return r;
    endfunction

    always_comb begin
        logic [7:0] rd_now;
        logic [7:0] vf_now;
        logic feed_now;
        logic feed_edge;
        logic slot;
        logic [7:0] gate;
        logic hit;
        rd_now = '0;
        vf_now = '0;
        feed_now = 1'b0;
        feed_edge = 1'b0;
        slot = 1'b0;
        gate = '0;
        hit = 1'b0;
        next_s = s;
        next_s.push = 1'b0;

        // Contacts are pins: two stages before any use
        next_s.rd_s1 = read_contact;
        next_s.rd_s2 = s.rd_s1;
        next_s.vf_s1 = verify_contact;
        next_s.vf_s2 = s.vf_s1;
        next_s.fd_s1 = feed_contact;
        next_s.fd_s2 = s.fd_s1;

        rd_now = pick8(s.rd_s2, reader_select);
        vf_now = pick8(s.vf_s2, reader_select);
        feed_now = |(s.fd_s2 & reader_select);
        next_s.feed_last = feed_now;
        // Only a transition after stepping counts as a feed hole
        feed_edge = (feed_now != s.feed_last) && s.steps != '0;

        // Step counter; a clear in the same cycle as a step keeps the step
        if (feed_edge) begin
            next_s.steps = reader_step ? 4'h1 : 4'h0;
        end else if (reader_step &&
                     s.steps != tape_verify_pkg::FEED_LIMIT) begin
            next_s.steps = s.steps + 4'h1;
        end
        // Alarm tracks the counter, so it holds until a clear
        next_s.falarm = (next_s.steps ==
                         tape_verify_pkg::FEED_LIMIT);

        // Slot sequencer: one down-counter, reloaded per slot
        slot = (s.timer == '0);
        if (s.timer != '0)
            next_s.timer = s.timer - TW'(1);
        unique case (s.phase)
            tape_verify_pkg::PH_IDLE: begin
            end
            tape_verify_pkg::PH_RESET: begin
                if (slot) begin
                    // Reset slot; verify follows 1.6 ms later
                    next_s.phase = tape_verify_pkg::PH_VERIFY;
                    next_s.timer = VFY_LD;
                end
            end
            tape_verify_pkg::PH_VERIFY: begin
                if (slot) begin
                    // Verify mark toggles, space leaves bit
                    next_s.storage = s.storage ^ vf_now;
                    next_s.phase = tape_verify_pkg::PH_ALARM;
                    next_s.timer = ALM_LD;
                end
            end
            tape_verify_pkg::PH_ALARM: begin
                if (slot) begin
                    // First sample after going on-line is skipped
                    hit = (|s.storage) && s.primed &&
                          !header_sending;
                    if (hit) begin
                        next_s.valarm = 1'b1;
                    end
                    // Clear so one bad character does not latch forever
                    next_s.storage = '0;
                    next_s.phase = tape_verify_pkg::PH_READ;
                    next_s.timer = RD_LD;
                end
            end
            tape_verify_pkg::PH_READ: begin
                // Stall here while the serializer queue is full
                if (slot && !fifo_full_q) begin
                    if (!header_sending) begin
                        next_s.storage = rd_now;
                    end
                    next_s.cavail = s.on_line &&
                                    !header_sending;
                    next_s.primed = s.on_line;
                    if (header_sending) begin
                        // Five-level code only
                        gate = {2'b00, header_levels, 1'b0};
                    end else if (next_s.cavail) begin
                        gate = rd_now;
                    end else begin
                        gate = tape_verify_pkg::IDLE_CHAR;
                    end
                    next_s.push = 1'b1;
                    next_s.push_data = gate;
                    next_s.phase = tape_verify_pkg::PH_IDLE;
                end
            end
        endcase

        // Step pulse opens a new character period
        if (reader_step) begin
            next_s.cavail = 1'b0;
            next_s.phase = tape_verify_pkg::PH_RESET;
            next_s.timer = RST_LD;
            // An alarm found in this same cycle still wins
            if (!hit)
                next_s.valarm = 1'b0;
        end
        if (!s.on_line)
            next_s.primed = 1'b0;

        // APB: answer one cycle into the access phase
        next_s.pready = psel && penable && !s.pready;
        next_s.pslverr = 1'b0;
        if (psel && penable && !s.pready) begin
            next_s.prdata = '0;
            unique case (paddr)
                tape_verify_pkg::CTRL_OFS:
                    next_s.prdata = {31'h0000_0000, s.on_line};
                tape_verify_pkg::STAT_OFS:
                    next_s.prdata = {16'h0000, s.storage, s.steps,
                                     fifo_full_q, s.cavail,
                                     s.falarm, s.valarm};
                tape_verify_pkg::CHAR_OFS:
                    next_s.prdata = {21'h00_0000, s.phase,
                                     s.push_data};
                default:
                    next_s.pslverr = 1'b1;
            endcase
        end
        // Write lands on the edge where pready is seen high
        if (psel && penable && s.pready && pwrite &&
            paddr == tape_verify_pkg::CTRL_OFS) begin
            next_s.on_line = pwdata[tape_verify_pkg::ONLINE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.on_line <= tape_verify_pkg::CTRL_RST[0];
            s.phase <= tape_verify_pkg::PH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    char_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(s.push),
        .in_ready(fifo_ready),
        .in_data(s.push_data),
        .out_valid(ser_valid),
        .out_ready(ser_ready),
        .out_data(ser_data)
    );

    // Registered full flag inside the queue
    assign fifo_full_q = !fifo_ready;

    // Outputs straight from state flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign verify_alarm = s.valarm;
    assign feed_alarm = s.falarm;
    assign char_available = s.cavail;
    assign step_permit = fifo_ready;
endmodule // tape_verify

// File: dv/tape_verify_checker.sv
`timescale 1ns/10ps
module tape_verify_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Reader side
    input wire logic [5:0] feed_contact,
    input wire logic [5:0] reader_select,
    input wire logic reader_step,
    input wire logic header_sending,
    // Outputs
    input wire logic [7:0] ser_data,
    input wire logic ser_valid,
    input wire logic ser_ready,
    input wire logic verify_alarm,
    input wire logic feed_alarm,
    input wire logic char_available
);
    logic [3:0] quiet;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since feed contacts moved; sync stages delay the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            quiet <= 4'hf;
        else if ((feed_contact & reader_select) !=
                 ($past(feed_contact) & reader_select))
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end
    apb_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    apb_answer_a: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("pready without access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ser_hold_a: assert property (ser_valid && !ser_ready |=>
        ser_valid && $stable(ser_data)) else $error("stalled char dropped");
    alarm_hold_a: assert property (verify_alarm && !reader_step |=>
        verify_alarm) else $error("verify alarm lost early");
    step_clear_a: assert property (reader_step |=>
        !verify_alarm && !char_available) else $error("step did not clear");
    alarm_header_a: assert property ($rose(verify_alarm) |->
        !$past(header_sending)) else $error("alarm during header");
    feed_rise_a: assert property ($rose(feed_alarm) |->
        $past(reader_step) || $past(reader_step, 2))
        else $error("feed alarm without step");
    feed_keep_a: assert property ($fell(feed_alarm) |->
        quiet < 4'h8) else $error("feed alarm dropped without feed");
    cover property (verify_alarm);
    cover property (feed_alarm);
    cover property (pslverr);
    cover property (ser_valid && !ser_ready);
endmodule // tape_verify_checker

bind tape_verify tape_verify_checker tape_verify_checker_i (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .feed_contact, .reader_select,
    .reader_step,
    .header_sending, .ser_data, .ser_valid, .ser_ready, .verify_alarm,
    .feed_alarm, .char_available);

// File: dv/tape_partner.sv
`timescale 1ns/10ps
module tape_partner #(
    parameter int RD = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic reader_step,
    input wire logic [7:0] tape_char,
    input wire logic [7:0] corrupt,
    input wire logic jam,
    input wire logic drain,
    // Contacts
    output logic [47:0] read_contact,
    output logic [47:0] verify_contact,
    output logic [5:0] feed_contact,
    // Serializer sink
    input wire logic [7:0] ser_data,
    input wire logic ser_valid,
    output logic ser_ready
);
    logic [7:0] rd, vf, noise;
    logic [3:0] feed_wait;
    logic feed;
    logic [7:0] got [0:15];
    int n_got;
    // Idle readers show a moving pattern, never a held value
    always_comb begin
        read_contact = {6{noise}};
        verify_contact = {6{~noise}};
        feed_contact = {6{noise[0]}};
        read_contact[RD*8 +: 8] = rd;
        verify_contact[RD*8 +: 8] = vf;
        feed_contact[RD] = feed;
    end
    assign ser_ready = drain;
    // Verify contact sees the row read one character before
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd <= 8'h00;
            vf <= 8'h00;
            noise <= 8'h00;
            feed <= 1'b1;
            feed_wait <= 4'h0;
            n_got <= 0;
        end else begin
            noise <= noise + 8'h01;
            if (reader_step) begin
                vf <= rd ^ corrupt;
                rd <= tape_char;
            end
            // Jammed tape never opens the feed contact
            if (reader_step && !jam) begin
                feed <= 1'b0;
                feed_wait <= 4'h3;
            end else if (feed_wait != 4'h0)
                feed_wait <= feed_wait - 4'h1;
            else
                feed <= 1'b1;
            if (ser_valid && ser_ready) begin
                got[n_got] <= ser_data;
                n_got <= n_got + 1;
            end
        end
    end
endmodule // tape_partner

// File: dv/test_tape_verify.sv
`timescale 1ns/10ps
module test_tape_verify;
    localparam int RC = 20;
    localparam int VC = 40;
    localparam int PERIOD = RC + VC + 5500 + 20;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, e, ser_valid, ser_ready, step_permit;
    logic verify_alarm, feed_alarm, char_available;
    logic [47:0] read_contact, verify_contact;
    logic [5:0] feed_contact, reader_select = 6'h04;
    logic reader_step = 0, header_sending = 0, jam = 0, drain = 0;
    logic [4:0] header_levels = 5'h13;
    logic [7:0] ser_data, tape_char = 8'h00, corrupt = 8'h00;
    logic [7:0] exp_q [$];
    int num_errors = 0, cmp_count = 0;
    // Clock
    always #20 pclk = ~pclk;
    tape_verify #(.RESET_CYC(RC), .VERIFY_CYC(VC)) tape_verify_i (.pclk,
        .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .read_contact, .verify_contact, .feed_contact,
        .reader_select, .reader_step, .header_sending, .header_levels,
        .ser_data, .ser_valid, .ser_ready, .step_permit, .verify_alarm,
        .feed_alarm, .char_available);
    tape_partner #(.RD(2)) tape_partner_i (.pclk, .presetn, .reader_step,
        .tape_char, .corrupt, .jam, .drain, .read_contact, .verify_contact,
        .feed_contact, .ser_data, .ser_valid, .ser_ready);
    task automatic summarize();
        $display("mismatches %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(string n, logic [31:0] x, logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", n, x, g);
            num_errors++;
        end
    endtask
    // Bus cycle held until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            num_errors++;
            summarize();
        end
    endtask
    // Steps only while the queue has room
    task automatic step();
        int i;
        for (i = 0; i < 50 && step_permit !== 1'b1; i++) @(posedge pclk);
        if (i == 50) begin
            num_errors++;
            summarize();
        end
        @(posedge pclk);
        reader_step <= 1'b1;
        @(posedge pclk);
        reader_step <= 1'b0;
    endtask
    task automatic period(logic [7:0] tc, cr, logic hs, ea, ec, logic [7:0] x);
        tape_char <= tc;
        corrupt <= cr;
        header_sending <= hs;
        step();
        repeat (PERIOD) @(posedge pclk);
        exp_q.push_back(x);
        check("verify_alarm", ea, verify_alarm);
        check("char_available", ec, char_available);
    endtask
    task automatic t_regs();
        apb(1'b0, tape_verify_pkg::CTRL_OFS, 32'h0000_0000);
        check("ctrl reset", tape_verify_pkg::CTRL_RST, r);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        check("unmapped err", 32'h0000_0001, e);
        check("unmapped data", 32'h0000_0000, r);
        apb(1'b1, tape_verify_pkg::CTRL_OFS, 32'h0000_0001);
        apb(1'b0, tape_verify_pkg::CTRL_OFS, 32'h0000_0000);
        check("ctrl on_line", 32'h0000_0001, r);
    endtask
    // Stalled sink: eight characters fill the queue, then drain in order
    task automatic t_stream();
        int i;
        period(8'ha5, 8'h00, 1'b0, 1'b0, 1'b1, 8'ha5);
        period(8'h3c, 8'h00, 1'b0, 1'b0, 1'b1, 8'h3c);
        period(8'h0f, 8'h81, 1'b0, 1'b1, 1'b1, 8'h0f);
        period(8'hf0, 8'h10, 1'b1, 1'b0, 1'b0, 8'h26);
        period(8'h66, 8'h00, 1'b0, 1'b1, 1'b1, 8'h66);
        period(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
        period(8'h81, 8'h00, 1'b0, 1'b0, 1'b1, 8'h81);
        check("step_permit full", 1'b0, step_permit);
        drain <= 1'b1;
        for (i = 0; i < 200 && tape_partner_i.n_got < 8; i++)
            @(posedge pclk);
        check("drained", 8, tape_partner_i.n_got);
        for (i = 0; i < 8; i++)
            check("ser_data", exp_q[i], tape_partner_i.got[i]);
        check("step_permit empty", 1'b1, step_permit);
    endtask
    // Jammed tape: fifteen steps raise the alarm, feed hole clears it
    task automatic t_feed();
        int i;
        jam <= 1'b1;
        for (i = 0; i < 14; i++) step();
        repeat (4) @(posedge pclk);
        check("feed_alarm 14", 1'b0, feed_alarm);
        step();
        repeat (20) @(posedge pclk);
        check("feed_alarm 15", 1'b1, feed_alarm);
        jam <= 1'b0;
        step();
        repeat (12) @(posedge pclk);
        check("feed_alarm cleared", 1'b0, feed_alarm);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        period(8'h31, 8'h00, 1'b0, 1'b0, 1'b0, 8'hff);
        t_regs();
        t_stream();
        t_feed();
        summarize();
    end
endmodule // test_tape_verify
